// ==== dtc_pkg.sv ====
`default_nettype none
package dtc_pkg;
  localparam int NCH = 4;
  localparam int AW = 24;
  localparam int BW = 16;
  localparam int RPW = 8;
  localparam int LW = BW + 1;
  localparam int NEV = 4;
  // Register address: bits 7:5 page (channel or global), bits 4:2 register
  localparam logic [2:0] PG_GLB = 3'h4;
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_BLOCK = 3'h1;
  localparam logic [2:0] R_REPEAT = 3'h2;
  localparam logic [2:0] R_SRC = 3'h3;
  localparam logic [2:0] R_DST = 3'h4;
  localparam logic [2:0] R_LEFT = 3'h5;
  localparam logic [2:0] G_CFG = 3'h0;
  localparam logic [2:0] G_STAT = 3'h1;
  localparam logic [2:0] G_MASK = 3'h2;
  localparam logic [2:0] G_BUSY = 3'h3;
  // Channel control fields
  localparam int F_EN = 0;
  localparam int F_SWTRIG = 1;
  localparam int F_BURST = 2;
  localparam int F_SMODE = 4;
  localparam int F_DMODE = 6;
  localparam int F_SRELOAD = 8;
  localparam int F_DRELOAD = 9;
  localparam int F_TRIG = 16;
  // Global config and status fields
  localparam int F_RROBIN = 0;
  localparam int F_LINK = 1;
  localparam int CFG_W = 3;
  localparam int ST_DONE = 0;
  localparam int ST_ERR = 4;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;
  localparam logic [7:0] TS_EV = 8'h01;
  localparam logic [3:0] TS_PER = 4'h1;
  localparam logic [15:0] TRIG_MASK [NCH] = '{16'h00ff, 16'h0ff0, 16'hff00, 16'hf00f};
  localparam logic [AW-1:0] EEP_BASE = 24'h001000;
  localparam logic [AW-1:0] EEP_SIZE = 24'h001000;
  localparam logic [AW-1:0] FLASH_BASE = 24'h800000;
  localparam logic [AW-1:0] FLASH_SIZE = 24'h800000;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] MAX_BURST = 4'h8;
  typedef enum logic [2:0] {S_IDLE, S_RD, S_CAP, S_WR, S_STEP} xfer_state_t;
endpackage
`default_nettype wire

// ==== channel_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module channel_arbiter (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] req,
  input  wire logic       rrobin,
  input  wire logic       take,
  output logic      [1:0] pick,
  output logic            any
);
  logic [1:0] last_q;
  logic [1:0] first;

  // Fixed order starts at channel 0, rotating order after the last winner
  assign first = rrobin ? last_q + 2'h1 : 2'h0;

  always_comb begin
    logic [1:0] idx;
    idx = 2'h0;
    pick = 2'h0;
    any = 1'b0;
    for (int k = dtc_pkg::NCH - 1; k >= 0; k--) begin
      idx = first + 2'(k);
      if (req[idx]) begin
        pick = idx;
        any = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_q <= 2'h0;
    end else if (take) begin
      last_q <= pick;
    end
  end
endmodule // channel_arbiter
`default_nettype wire

// ==== direct_transfer_controller.sv ====
// Functional notes
// - Four channels, each independently configured
// - Block length one byte to 64K bytes
// - Repeat counter reruns block, up to 255 times
// - Independent increment, decrement or static addressing
// - Optional address reload at transaction end
// - Bursts of 1, 2, 4 or 8 bytes
// - Software selects fixed or rotating priority
// - Paired channels hand over on completion
// - Transfers share the processor data bus
// - EEPROM read only, flash never accessed
// - Peripheral, event or software triggers per channel
// - Memory and peripherals both source and destination
`timescale 1ns/1ps
`default_nettype none
module direct_transfer_controller (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] periph_req,
  input  wire logic [3:0]  event_in,
  output logic             bus_req,
  input  wire logic        bus_gnt,
  output logic      [23:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic             irq
);
  localparam int N = dtc_pkg::NCH;

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [1:0] m);
    return (m == dtc_pkg::AM_INC) ? a + 24'h1 : (m == dtc_pkg::AM_DEC) ? a - 24'h1 : a;
  endfunction

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] b, input logic [23:0] s);
    logic [23:0] off;
    off = a - b;
    return off < s;
  endfunction

  function automatic logic [16:0] blk_len(input logic [15:0] b);
    return {b == 16'h0, b};
  endfunction

  function automatic logic trig_hit(input logic [7:0] s, input logic [15:0] m,
                                    input logic [15:0] p, input logic [3:0] e);
    logic [7:0] ev;
    ev = s - dtc_pkg::TS_EV;
    if (ev < 8'(dtc_pkg::NEV)) begin
      return e[ev[1:0]];
    end
    return (s[7:4] == dtc_pkg::TS_PER) && p[s[3:0]] && m[s[3:0]];
  endfunction

  // Per-channel configuration and working state
  logic [N-1:0]  en_q;
  logic [N-1:0]  pend_q;
  logic [N-1:0]  srel_q;
  logic [N-1:0]  drel_q;
  logic [1:0]    burst_q [N];
  logic [1:0]    smode_q [N];
  logic [1:0]    dmode_q [N];
  logic [7:0]    trig_q  [N];
  logic [15:0]   blk_q   [N];
  logic [7:0]    rep_q   [N];
  logic [23:0]   sbase_q [N];
  logic [23:0]   dbase_q [N];
  logic [23:0]   scur_q  [N];
  logic [23:0]   dcur_q  [N];
  logic [16:0]   left_q  [N];
  logic [7:0]    rleft_q [N];

  // Engine and register file state
  dtc_pkg::xfer_state_t state_q;
  logic [1:0]    sel_q;
  logic [3:0]    bcnt_q;
  logic [2:0]    cfg_q;
  logic [7:0]    stat_q;
  logic [7:0]    mask_q;
  logic [31:0]   rdata_q;
  logic          irq_q;
  logic          bus_req_q;
  logic          mem_rd_q;
  logic          mem_wr_q;
  logic [23:0]   mem_addr_q;
  logic [7:0]    mem_wdata_q;

  logic [N-1:0]  ch_wr;
  logic [N-1:0]  ctrl_wr;
  logic [N-1:0]  arm;
  logic [N-1:0]  link_arm;
  logic [N-1:0]  pend_set;
  logic [N-1:0]  take;
  logic [N-1:0]  mine;
  logic [N-1:0]  done_ev;
  logic [N-1:0]  err_ev;
  logic [1:0]    arb_pick;
  logic          arb_any;
  logic [2:0]    ri;
  logic [1:0]    rc;
  logic          glb_wr;
  logic          step_ev;
  logic          bad;
  logic          bad_ev;
  logic [23:0]   cur_src;
  logic [23:0]   cur_dst;
  logic          blk_last;
  logic          txn_last;
  logic          burst_last;
  logic [7:0]    stat_d;
  logic [31:0]   rd_mux;

  assign ri = reg_addr[4:2];
  assign rc = reg_addr[6:5];
  assign glb_wr = reg_wr && reg_addr[7:5] == dtc_pkg::PG_GLB;
  assign cur_src = scur_q[sel_q];
  assign cur_dst = dcur_q[sel_q];
  assign blk_last = left_q[sel_q] == 17'h1;
  assign txn_last = blk_last && rleft_q[sel_q] == 8'h0;
  assign burst_last = bcnt_q == 4'h1;
  assign step_ev = state_q == dtc_pkg::S_STEP;
  // Never read flash, never write flash or EEPROM
  assign bad = in_rng(cur_src, dtc_pkg::FLASH_BASE, dtc_pkg::FLASH_SIZE) ||
               in_rng(cur_dst, dtc_pkg::FLASH_BASE, dtc_pkg::FLASH_SIZE) ||
               in_rng(cur_dst, dtc_pkg::EEP_BASE, dtc_pkg::EEP_SIZE);
  assign bad_ev = state_q == dtc_pkg::S_RD && bus_gnt && bad;

  for (genvar c = 0; c < N; c++) begin : g_ch
    assign ch_wr[c] = reg_wr && !reg_addr[7] && rc == 2'(c);
    assign ctrl_wr[c] = ch_wr[c] && ri == dtc_pkg::R_CTRL;
    assign link_arm[c] = done_ev[c ^ 1] && cfg_q[dtc_pkg::F_LINK + c / 2];
    assign arm[c] = (ctrl_wr[c] && reg_wdata[dtc_pkg::F_EN] && !en_q[c]) || link_arm[c];
    assign pend_set[c] = (en_q[c] && trig_hit(trig_q[c], dtc_pkg::TRIG_MASK[c], periph_req, event_in)) ||
                         (ctrl_wr[c] && reg_wdata[dtc_pkg::F_SWTRIG]);
    assign mine[c] = sel_q == 2'(c);
    assign take[c] = state_q == dtc_pkg::S_IDLE && arb_any && arb_pick == 2'(c);
    assign done_ev[c] = step_ev && mine[c] && txn_last;
    assign err_ev[c] = bad_ev && mine[c];
  end

  channel_arbiter u_arb (
    .sys_clk (sys_clk),
    .rst     (rst),
    .req     (pend_q & en_q),
    .rrobin  (cfg_q[dtc_pkg::F_RROBIN]),
    .take    (|take),
    .pick    (arb_pick),
    .any     (arb_any)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q <= '0;
      pend_q <= '0;
      srel_q <= '0;
      drel_q <= '0;
      for (int c = 0; c < N; c++) begin
        burst_q[c] <= 2'h0;
        smode_q[c] <= 2'h0;
        dmode_q[c] <= 2'h0;
        trig_q[c] <= 8'h00;
        blk_q[c] <= 16'h0000;
        rep_q[c] <= 8'h00;
        sbase_q[c] <= 24'h000000;
        dbase_q[c] <= 24'h000000;
        scur_q[c] <= 24'h000000;
        dcur_q[c] <= 24'h000000;
        left_q[c] <= 17'h00000;
        rleft_q[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        // A trigger in the cycle of its take is kept
        pend_q[c] <= pend_set[c] || (pend_q[c] && !take[c] && !err_ev[c]);
        if (ch_wr[c]) begin
          unique case (ri)
            dtc_pkg::R_CTRL: begin
              en_q[c] <= reg_wdata[dtc_pkg::F_EN];
              burst_q[c] <= reg_wdata[dtc_pkg::F_BURST +: 2];
              smode_q[c] <= reg_wdata[dtc_pkg::F_SMODE +: 2];
              dmode_q[c] <= reg_wdata[dtc_pkg::F_DMODE +: 2];
              srel_q[c] <= reg_wdata[dtc_pkg::F_SRELOAD];
              drel_q[c] <= reg_wdata[dtc_pkg::F_DRELOAD];
              trig_q[c] <= reg_wdata[dtc_pkg::F_TRIG +: 8];
            end
            dtc_pkg::R_BLOCK: blk_q[c] <= reg_wdata[15:0];
            dtc_pkg::R_REPEAT: rep_q[c] <= reg_wdata[7:0];
            dtc_pkg::R_SRC: begin
              sbase_q[c] <= reg_wdata[23:0];
              scur_q[c] <= reg_wdata[23:0];
            end
            dtc_pkg::R_DST: begin
              dbase_q[c] <= reg_wdata[23:0];
              dcur_q[c] <= reg_wdata[23:0];
            end
            default: ;
          endcase
        end
        if (arm[c]) begin
          en_q[c] <= 1'b1;
          left_q[c] <= blk_len(blk_q[c]);
          rleft_q[c] <= rep_q[c];
        end
        if (step_ev && mine[c]) begin
          // Each side steps by its own mode
          scur_q[c] <= (txn_last && srel_q[c]) ? sbase_q[c] : next_addr(scur_q[c], smode_q[c]);
          dcur_q[c] <= (txn_last && drel_q[c]) ? dbase_q[c] : next_addr(dcur_q[c], dmode_q[c]);
          if (txn_last) begin
            en_q[c] <= 1'b0;
          end else if (blk_last) begin
            left_q[c] <= blk_len(blk_q[c]);
            rleft_q[c] <= rleft_q[c] - 8'h1;
          end else begin
            left_q[c] <= left_q[c] - 17'h1;
          end
        end
        if (err_ev[c]) begin
          en_q[c] <= 1'b0;
        end
      end
    end
  end

  // One byte: read source, capture, write destination, step counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= dtc_pkg::S_IDLE;
      sel_q <= 2'h0;
      bcnt_q <= 4'h0;
      bus_req_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= 24'h000000;
      mem_wdata_q <= 8'h00;
    end else begin
      unique case (state_q)
        dtc_pkg::S_IDLE: if (arb_any) begin
          sel_q <= arb_pick;
          bcnt_q <= 4'h1 << burst_q[arb_pick];
          bus_req_q <= 1'b1;
          state_q <= dtc_pkg::S_RD;
        end
        dtc_pkg::S_RD: if (bad_ev) begin
          bus_req_q <= 1'b0;
          state_q <= dtc_pkg::S_IDLE;
        end else if (bus_gnt) begin
          mem_rd_q <= 1'b1;
          mem_addr_q <= cur_src;
          state_q <= dtc_pkg::S_CAP;
        end
        dtc_pkg::S_CAP: begin
          mem_rd_q <= 1'b0;
          state_q <= dtc_pkg::S_WR;
        end
        dtc_pkg::S_WR: begin
          mem_wr_q <= 1'b1;
          mem_addr_q <= cur_dst;
          mem_wdata_q <= mem_rdata;
          state_q <= dtc_pkg::S_STEP;
        end
        dtc_pkg::S_STEP: begin
          mem_wr_q <= 1'b0;
          bcnt_q <= bcnt_q - 4'h1;
          if (txn_last || burst_last) begin
            bus_req_q <= 1'b0;
            state_q <= dtc_pkg::S_IDLE;
          end else begin
            state_q <= dtc_pkg::S_RD;
          end
        end
      endcase
    end
  end

  // Sticky flags: hardware set wins over write-one-to-clear
  assign stat_d = (stat_q & ~(glb_wr && ri == dtc_pkg::G_STAT ? reg_wdata[7:0] : 8'h00)) |
                  {err_ev, done_ev};

  always_comb begin
    rd_mux = 32'h0;
    if (!reg_addr[7]) begin
      unique case (ri)
        dtc_pkg::R_CTRL: rd_mux = {8'h0, trig_q[rc], 6'h0, drel_q[rc], srel_q[rc], dmode_q[rc],
                                   smode_q[rc], burst_q[rc], 1'b0, en_q[rc]};
        dtc_pkg::R_BLOCK: rd_mux = {16'h0, blk_q[rc]};
        dtc_pkg::R_REPEAT: rd_mux = {24'h0, rep_q[rc]};
        dtc_pkg::R_SRC: rd_mux = {8'h0, scur_q[rc]};
        dtc_pkg::R_DST: rd_mux = {8'h0, dcur_q[rc]};
        dtc_pkg::R_LEFT: rd_mux = {7'h0, rleft_q[rc], left_q[rc]};
        default: rd_mux = 32'h0;
      endcase
    end else if (reg_addr[7:5] == dtc_pkg::PG_GLB) begin
      unique case (ri)
        dtc_pkg::G_CFG: rd_mux = {29'h0, cfg_q};
        dtc_pkg::G_STAT: rd_mux = {24'h0, stat_q};
        dtc_pkg::G_MASK: rd_mux = {24'h0, mask_q};
        dtc_pkg::G_BUSY: rd_mux = {21'h0, state_q != dtc_pkg::S_IDLE, sel_q, pend_q, en_q};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 3'h0;
      stat_q <= dtc_pkg::STAT_RST;
      mask_q <= 8'h00;
      rdata_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      if (glb_wr && ri == dtc_pkg::G_CFG) begin
        cfg_q <= reg_wdata[dtc_pkg::CFG_W-1:0];
      end
      if (glb_wr && ri == dtc_pkg::G_MASK) begin
        mask_q <= reg_wdata[7:0];
      end
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign bus_req = bus_req_q;
  assign mem_addr = mem_addr_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_wdata = mem_wdata_q;
  assign irq = irq_q;

  // Bytes moved in one bus tenure
  logic [3:0] tenure_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tenure_q <= 4'h0;
    end else begin
      tenure_q <= !bus_req_q ? 4'h0 : tenure_q + {3'h0, mem_wr_q};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_read;
    mem_rd_q;
  endsequence
  sequence s_write_back;
    ##2 (mem_wr_q && mem_wdata_q == $past(mem_rdata));
  endsequence

  property p_move;
    s_read |-> s_write_back;
  endproperty
  a_move: assert property (p_move) else $error("read not followed by write");

  property p_bus_held;
    (mem_rd_q || mem_wr_q) |-> bus_req_q;
  endproperty
  a_bus_held: assert property (p_bus_held) else $error("access without bus request");

  property p_gnt_before_rd;
    $rose(mem_rd_q) |-> $past(bus_gnt);
  endproperty
  a_gnt_before_rd: assert property (p_gnt_before_rd) else $error("read without grant");

  property p_no_flash_rd;
    mem_rd_q |-> !in_rng(mem_addr_q, dtc_pkg::FLASH_BASE, dtc_pkg::FLASH_SIZE);
  endproperty
  a_no_flash_rd: assert property (p_no_flash_rd) else $error("flash read");

  property p_no_nv_wr;
    mem_wr_q |-> !in_rng(mem_addr_q, dtc_pkg::FLASH_BASE, dtc_pkg::FLASH_SIZE) &&
                 !in_rng(mem_addr_q, dtc_pkg::EEP_BASE, dtc_pkg::EEP_SIZE);
  endproperty
  a_no_nv_wr: assert property (p_no_nv_wr) else $error("nonvolatile write");

  property p_burst_max;
    tenure_q <= dtc_pkg::MAX_BURST;
  endproperty
  a_burst_max: assert property (p_burst_max) else $error("burst too long");

  property p_done_stop;
    (|done_ev) |=> ((stat_q & {4'h0, $past(done_ev)}) == {4'h0, $past(done_ev)}) &&
                   ((en_q & $past(done_ev)) == 4'h0);
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("completion not flagged");

  property p_link;
    (done_ev[0] && cfg_q[dtc_pkg::F_LINK]) |=> en_q[1];
  endproperty
  a_link: assert property (p_link) else $error("linked channel not started");

  property p_src_step;
    (step_ev && !txn_last && smode_q[sel_q] == dtc_pkg::AM_DEC) |=> cur_src == $past(cur_src) - 24'h1;
  endproperty
  a_src_step: assert property (p_src_step) else $error("source decrement wrong");

  property p_reload;
    (step_ev && txn_last && srel_q[sel_q]) |=> cur_src == sbase_q[sel_q];
  endproperty
  a_reload: assert property (p_reload) else $error("source not reloaded");
endmodule // direct_transfer_controller
`default_nettype wire

// ==== bus_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        bus_req,
  input  wire logic        stall,
  input  wire logic        mem_rd,
  input  wire logic [23:0] mem_addr,
  output logic             bus_gnt,
  output logic      [7:0]  mem_rdata
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_gnt   <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      // Grant kept while the request stays up; stall delays a new grant
      bus_gnt   <= bus_req & (bus_gnt | ~stall);
      // Data valid one cycle only, otherwise a changing pattern
      mem_rdata <= mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c) : ~mem_rdata;
    end
  end
endmodule // bus_partner
`default_nettype wire

// ==== direct_transfer_controller_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module direct_transfer_controller_test;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] periph_req = 16'h0;
  logic [3:0]  event_in = 4'h0;
  logic        bus_req, bus_gnt, mem_rd, mem_wr, irq;
  logic [23:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [23:0] rq[$];
  logic [31:0] wq[$];
  logic [31:0] v;
  int          err_total = 0;
  int          checked = 0;
  int          bad = 0;
  int          k, m, j;
  logic [7:0]  ra[9] = '{8'h04, 8'h28, 8'h4c, 8'h70, 8'h20, 8'h80, 8'h80, 8'h98, 8'h74};
  logic [31:0] rw[9] = '{32'h0000ffff, 32'h000001ff, 32'hff123456, 32'h00abcdef, 32'h00ab02fc,
                         32'h000000ff, 32'h0, 32'hffffffff, 32'hffffffff};
  logic [31:0] re[9] = '{32'h0000ffff, 32'h000000ff, 32'h00123456, 32'h00abcdef, 32'h00ab02fc,
                         32'h00000007, 32'h0, 32'h0, 32'h0};

  always #25 sys_clk = ~sys_clk;

  direct_transfer_controller DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .periph_req, .event_in, .bus_req, .bus_gnt, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .irq);
  bus_partner far_end (.sys_clk, .rst, .bus_req, .stall, .mem_rd, .mem_addr, .bus_gnt, .mem_rdata);

  always @(posedge sys_clk) begin
    if (mem_rd) rq.push_back(mem_addr);
    if (mem_wr) wq.push_back({mem_wdata, mem_addr});
    if ((mem_rd || mem_wr) && mem_addr >= dtc_pkg::FLASH_BASE) bad++;
    if (mem_wr && mem_addr >= dtc_pkg::EEP_BASE && mem_addr < dtc_pkg::EEP_BASE + dtc_pkg::EEP_SIZE) bad++;
  end

  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Polls until no enabled channel is pending and the engine is quiet
  task automatic idle();
    repeat (3) @(posedge sys_clk);
    for (j = 0; j < 100; j++) begin
      rd(8'h8c);
      if (v[10] === 1'b0 && (v[7:4] & v[3:0]) === 4'h0) break;
    end
    if (j == 100) chk("idle", 0, 1);
    @(posedge sys_clk);
  endtask

  task automatic setup(input int c, input logic [15:0] b, input logic [7:0] r, input logic [23:0] s,
                       input logic [23:0] d, input logic [31:0] ctl);
    logic [7:0] a;
    a = 8'(c * 32);
    wr(a + 8'h04, {16'h0, b});
    wr(a + 8'h08, {24'h0, r});
    wr(a + 8'h0c, {8'h0, s});
    wr(a + 8'h10, {8'h0, d});
    wr(a, ctl);
  endtask

  task automatic burst(input int c, input logic [31:0] ctl);
    wr(8'(c * 32), ctl | 32'h2);
    idle();
  endtask

  task automatic xfer(input int n, input logic [23:0] s, input int ss, input logic [23:0] d, input int ds);
    for (int i = 0; i < n; i++) chk("data", wq[k + i], {pat(s + 24'(ss * i)), d + 24'(ds * i)});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'h80 + 8'(4 * i));
      chk("reset reg", v, 0);
    end
    chk("reset pins", 32'({bus_req, mem_rd, mem_wr, irq}), 0);
    foreach (ra[i]) begin
      wr(ra[i], rw[i]);
      rd(ra[i]);
      chk("reg", v, re[i]);
    end
    // Two single-byte bursts, source down, destination up
    wr(8'h88, 32'h1);
    setup(0, 16'h2, 8'h0, 24'h000200, 24'h000310, 32'h61);
    k = wq.size();
    burst(0, 32'h61);
    chk("burst1", wq.size() - k, 1);
    rd(8'h84);
    chk("not done", v, 0);
    burst(0, 32'h61);
    xfer(2, 24'h200, -1, 24'h310, 1);
    rd(8'h84);
    chk("done", v, 32'h1);
    rd(8'h8c);
    chk("ch0 off", v & 32'h1, 0);
    chk("irq up", irq, 1);
    wr(8'h84, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq clear", irq, 0);
    // Four-byte bursts, block run twice, static source, reload
    setup(3, 16'h4, 8'h1, 24'h000040, 24'h000400, 32'h349);
    k = wq.size();
    burst(3, 32'h349);
    chk("burst4", wq.size() - k, 4);
    burst(3, 32'h349);
    xfer(8, 24'h40, 0, 24'h400, 1);
    rd(8'h84);
    chk("done ch3", v, 32'h8);
    chk("irq masked", irq, 0);
    rd(8'h6c);
    chk("src reload", v, 32'h40);
    rd(8'h70);
    chk("dst reload", v, 32'h400);
    wr(8'h84, 32'hff);
    // Forbidden regions are refused without any access
    for (int i = 0; i < 2; i++) begin
      m = rq.size() + wq.size();
      setup(2, 16'h1, 8'h0, i ? 24'h800000 : 24'h001000, i ? 24'h000100 : 24'h001010, 32'h51);
      burst(2, 32'h51);
      chk("no access", rq.size() + wq.size() - m, 0);
      rd(8'h84);
      chk("err flag", v, 32'h40);
      wr(8'h84, 32'h40);
    end
    setup(2, 16'h1, 8'h0, 24'h001020, 24'h000800, 32'h00020051);
    k = wq.size();
    event_in <= 4'h2;
    idle();
    event_in <= 4'h0;
    xfer(1, 24'h1020, 0, 24'h800, 0);
    wr(8'h84, 32'hff);
    // Paired channels hand over both ways
    wr(8'h80, 32'h2);
    setup(1, 16'h1, 8'h0, 24'h000500, 24'h000600, 32'h00140050);
    setup(0, 16'h1, 8'h0, 24'h000700, 24'h000710, 32'h51);
    burst(0, 32'h51);
    rd(8'h8c);
    chk("link 0 to 1", v & 32'h3, 32'h2);
    k = wq.size();
    periph_req <= 16'h0010;
    idle();
    periph_req <= 16'h0;
    xfer(1, 24'h500, 0, 24'h600, 0);
    rd(8'h8c);
    chk("link 1 to 0", v & 32'h3, 32'h1);
    wr(8'h00, 32'h00180051);
    m = rq.size();
    periph_req <= 16'h0100;
    repeat (20) @(posedge sys_clk);
    periph_req <= 16'h0;
    chk("bad trigger", rq.size() - m, 0);
    wr(8'h00, 32'h0);
    wr(8'h80, 32'h0);
    wr(8'h84, 32'hff);
    // Same event on two channels under a slow grant: channel 0 first
    setup(3, 16'h1, 8'h0, 24'h000900, 24'h000910, 32'h00010051);
    setup(0, 16'h1, 8'h0, 24'h000a00, 24'h000a10, 32'h00010051);
    m = rq.size();
    stall    <= 1'b1;
    event_in <= 4'h1;
    repeat (10) @(posedge sys_clk);
    stall <= 1'b0;
    idle();
    event_in <= 4'h0;
    chk("first", rq[m], 24'h000a00);
    chk("second", rq[m + 1], 24'h000900);
    // Reset while the engine waits for the bus
    setup(0, 16'h1, 8'h0, 24'h000b00, 24'h000b10, 32'h51);
    idle();
    wr(8'h88, 32'hf);
    stall <= 1'b1;
    wr(8'h00, 32'h53);
    repeat (4) @(posedge sys_clk);
    #1 chk("waiting", bus_req, 1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst   <= 1'b0;
    stall <= 1'b0;
    #1 chk("reset pins", 32'({bus_req, mem_rd, mem_wr, irq}), 0);
    rd(8'h88);
    chk("mask reset", v, 0);
    rd(8'h8c);
    chk("busy reset", v, 0);
    chk("illegal access", bad, 0);
    stop_test();
  end
endmodule // direct_transfer_controller_test
`default_nettype wire
